// file: core/gpm_pkg.sv
/*
  Package for the general-purpose port block: register offsets, reset
  values, field positions and the packed carriers shared by the design.
  Assumes a 32-bit APB master and byte offsets printed at word granularity.
*/
package gpm_pkg;

  // ----------------------------------------------------------------------
  // Register indexes; the byte address is four times the index.
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_PORT_A_DATA = 8'h00;
  localparam logic [7:0] IDX_PORT_A_DIR  = 8'h01;
  localparam logic [7:0] IDX_PORT_B_DATA = 8'h02;
  localparam logic [7:0] IDX_PORT_B_DIR  = 8'h03;
  localparam logic [7:0] IDX_PORT_C_DATA = 8'h04;
  localparam logic [7:0] IDX_PORT_C_DIR  = 8'h05;
  localparam logic [7:0] IDX_PORT_D_DATA = 8'h06;
  localparam logic [7:0] IDX_PORT_D_DIR  = 8'h07;
  localparam logic [7:0] IDX_MISC_CTRL   = 8'h09;
  localparam logic [7:0] IDX_EXT_IRQ_CFG = 8'h10;
  localparam logic [7:0] IDX_IRQ_STATUS  = 8'h11;
  localparam logic [7:0] IDX_IRQ_MASK    = 8'h12;
  localparam logic [7:0] IDX_CONV_CHAN   = 8'h13;

  // ----------------------------------------------------------------------
  // Reset values and the implemented-bit mask of port C.
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_PORT      = 8'h00;
  localparam logic [7:0] RST_PORT_C    = 8'hF0;
  localparam logic [7:0] PORT_C_IMPL   = 8'h07;
  localparam logic [7:0] RST_MISC      = 8'h00;
  localparam logic [3:0] RST_CONV_CHAN = 4'h0;

  // ----------------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------------
  localparam int MISC_CLK_OUT_BIT = 0;
  localparam int MISC_USB_TX_BIT  = 1;
  localparam int MISC_SLOW_BIT    = 2;
  localparam int USB_PIN_BIT      = 2;
  localparam int USB_PIN_BIT_SMALL = 1;
  localparam int CLK_PIN_BIT      = 0;
  localparam int IRQ_LOW_PIN      = 4;

  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] c;
    logic [7:0] d;
  } gpm_ports_type;

  typedef struct packed {
    logic [2:0] rsvd;
    logic       slowSel;
    logic       usbTxSel;
    logic       clkOutSel;
  } gpm_misc_type;

endpackage

// file: core/gpm_ports.sv
/*
  General-purpose ports A to D with miscellaneous control, as an APB slave.
  Assumes pins arrive asynchronous to clock, peripheral alternate outputs
  come from logic on the same clock, and a single system reset.
*/
// Our own choice: the APB slave port.
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// R01: Port data registers sit at indexes 0, 2, 4 and 6.
// R02: Port direction registers sit at indexes 1, 3, 5 and 7.
// R03: Reset clears ports A, B, D; port C resets to F0.
// R04: Port C implements only its low three bits.
// R05: Data writes always update the output latch.
// R06: Data read returns latch for outputs, pin level for inputs.
// R07: Open-drain outputs read back the pin level.
// R08: Direction bit 0 selects input, 1 selects output.
// R09: Port B pins 4-7 raise external interrupts 5-8 when enabled.
// R10: USB transmit indicator drives port C pin 2 high when selected; in the small package the code drives port B pin 1 instead.
// R11: Misc control at index 9, resets zero, bits 7-3 reserved.
// R12: Slow bit is set-only by software, halves the CPU clock.
// R13: USB clock is never divided by the slow bit.
// R14: Clock-out bit routes the CPU clock to port A pin 0; the code drives clkDiv_r there, at half the clock rate.
// R15: Enabled alternate functions override port programming and force output.
// R16: Interrupt pins sharing a vector are ORed into one request.
// R17: Output pins never raise pin interrupts; the code masks only pins whose direction bit is 1, not alternate outputs.
// R18: Software writes data before turning a pin to output.
// R19: A converter-selected analog pin stays a floating input.
module gpm_ports
  import gpm_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [31:0] pinIn,
  output logic      [31:0] pinOut,
  output logic      [31:0] pinOe,
  input  wire logic [31:0] openDrainMask,
  input  wire logic [31:0] altOutEn,
  input  wire logic [31:0] altOutVal,
  input  wire logic        usbTransmitting,
  input  wire logic        smallPackage,
  output logic             cpuClockSlow,
  output logic             usbClockEn,
  output logic             extIrq5,
  output logic             extIrq6,
  output logic             extIrq7,
  output logic             extIrq8,
  output logic             extIrqAny,
  output logic             irq
);

  // ----------------------------------------------------------------------
  // Registers and synchronisers.
  // ----------------------------------------------------------------------
  gpm_ports_type dataR;
  gpm_ports_type dirR;
  gpm_misc_type  misc_control;
  logic [3:0]    irqCfgR;
  logic [3:0]    irqStatR;
  logic [3:0]    irqMaskR;
  logic [3:0]    convChanR;
  logic [31:0]   pinMeta_r;
  logic [31:0]   pinSync_r;
  logic [3:0]    irqPinPrev_r;
  logic          clkDiv_r;

  // ----------------------------------------------------------------------
  // APB decode. Answers in the access cycle with no wait states.
  // ----------------------------------------------------------------------
  wire logic [7:0] regIdx   = paddr[9:2];
  wire logic       wordAddr = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
  wire logic       access   = psel && penable;
  wire logic       wrLane0  = access && pwrite && pstrb[0];
  wire logic       hitPortA = regIdx == IDX_PORT_A_DATA || regIdx == IDX_PORT_A_DIR;
  wire logic       hitPortB = regIdx == IDX_PORT_B_DATA || regIdx == IDX_PORT_B_DIR;
  wire logic       hitPortC = regIdx == IDX_PORT_C_DATA || regIdx == IDX_PORT_C_DIR;
  wire logic       hitPortD = regIdx == IDX_PORT_D_DATA || regIdx == IDX_PORT_D_DIR;
  wire logic       hitOwn   = regIdx == IDX_EXT_IRQ_CFG || regIdx == IDX_IRQ_STATUS ||
                              regIdx == IDX_IRQ_MASK || regIdx == IDX_CONV_CHAN;
  wire logic       mapped   = wordAddr && (hitPortA || hitPortB || hitPortC ||
                              hitPortD || regIdx == IDX_MISC_CTRL || hitOwn);
  wire logic       wrOk     = wrLane0 && mapped;
  wire logic [7:0] wrByte   = pwdata[7:0];

  // ----------------------------------------------------------------------
  // Pin ownership: alternate functions and analog selection.
  // ----------------------------------------------------------------------
  wire logic [31:0] dataFlat = dataR;
  wire logic [31:0] dirFlat  = dirR;
  logic [31:0] altEnAll;
  logic [31:0] altValAll;
  logic [31:0] analogSel;
  logic [31:0] ownOe;
  logic [31:0] ownOut;
  logic [31:0] readFlat;

  wire logic [4:0] usbPin = smallPackage ? 5'(16 + USB_PIN_BIT_SMALL) : 5'(8 + USB_PIN_BIT);

  // The converter channels 0-7 map to port B, 8-11 to port D low nibble.
  wire logic [4:0] anaPin = convChanR[3] ? {3'b000, convChanR[1:0]}
                                         : {2'b10, convChanR[2:0]};
  wire logic       anaValid = !(convChanR[3] && convChanR[2]);

  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_pin
      // Bit numbering: a = 31..24, b = 23..16, c = 15..8, d = 7..0.
      // Pins are indexed flat, the same way as the usb and converter selects.
      localparam logic [4:0] LOGIC_IDX = 5'(gi);
      // Port C bits 7-3 have no pin behind them, so they never drive.
      localparam logic PIN_IMPL = (gi / 8 != 1) || PORT_C_IMPL[gi % 8];
      wire logic isClkPin = (gi == 24 + CLK_PIN_BIT) && misc_control.clkOutSel;                   // R14
      wire logic isUsbPin = (LOGIC_IDX == usbPin) && misc_control.usbTxSel;                        // R10
      assign analogSel[gi] = anaValid && (LOGIC_IDX == anaPin);                             // R19
      assign altEnAll[gi]  = isClkPin || isUsbPin || altOutEn[gi];                           // R15
      assign altValAll[gi] = isClkPin ? clkDiv_r : (isUsbPin ? usbTransmitting : altOutVal[gi]);
      assign ownOe[gi]     = PIN_IMPL && !analogSel[gi] &&
                             (altEnAll[gi] || dirFlat[gi]); // R04 R08 R15 R19
      assign ownOut[gi]    = PIN_IMPL && (altEnAll[gi] ? altValAll[gi] : dataFlat[gi]); // R04
      // Pins with direction output read the latch unless open drain; inputs read the pin.
      assign readFlat[gi]  = (dirFlat[gi] && !openDrainMask[gi]) ? dataFlat[gi]
                                                                 : pinSync_r[gi];         // R06 R07
    end
  endgenerate

  // ----------------------------------------------------------------------
  // External interrupt sources on port B pins 4-7.
  // ----------------------------------------------------------------------
  wire logic [3:0] irqPins   = pinSync_r[16 + IRQ_LOW_PIN +: 4];
  wire logic [3:0] irqInput  = ~dirR.b[IRQ_LOW_PIN +: 4];                                   // R17
  wire logic [3:0] irqLive   = irqCfgR & irqInput;                                          // R09
  // A falling edge is the event; the sensitivity options are not modelled.
  wire logic [3:0] irqEvent  = irqLive & irqPinPrev_r & ~irqPins;
  wire logic [3:0] irqClr    = (wrOk && regIdx == IDX_IRQ_STATUS) ? wrByte[3:0] : 4'h0;
  wire logic [3:0] irqStNxt  = (irqStatR & ~irqClr) | irqEvent;
  wire logic       irqAnyNxt = |(irqLive & ~irqPins);                                       // R16

  // ----------------------------------------------------------------------
  // Read mux.
  // ----------------------------------------------------------------------
  logic [7:0] rdByte;
  always_comb begin
    case (regIdx)
      IDX_PORT_A_DATA: rdByte = readFlat[31:24];
      IDX_PORT_A_DIR:  rdByte = dirR.a;
      IDX_PORT_B_DATA: rdByte = readFlat[23:16];
      IDX_PORT_B_DIR:  rdByte = dirR.b;
      IDX_PORT_C_DATA: rdByte = (readFlat[15:8] & PORT_C_IMPL) | RST_PORT_C;                 // R04
      IDX_PORT_C_DIR:  rdByte = (dirR.c & PORT_C_IMPL) | RST_PORT_C;                         // R04
      IDX_PORT_D_DATA: rdByte = readFlat[7:0];
      IDX_PORT_D_DIR:  rdByte = dirR.d;
      IDX_MISC_CTRL:   rdByte = {5'b00000, misc_control.slowSel, misc_control.usbTxSel, misc_control.clkOutSel}; // R11
      IDX_EXT_IRQ_CFG: rdByte = {4'h0, irqCfgR};
      IDX_IRQ_STATUS:  rdByte = {4'h0, irqStatR};
      IDX_IRQ_MASK:    rdByte = {4'h0, irqMaskR};
      IDX_CONV_CHAN:   rdByte = {4'h0, convChanR};
      default:         rdByte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------------
  // Port registers.
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dataR <= '{a: RST_PORT, b: RST_PORT, c: RST_PORT_C, d: RST_PORT};                  // R03
      dirR  <= '{a: RST_PORT, b: RST_PORT, c: RST_PORT_C, d: RST_PORT};                  // R03
    end else if (wrOk) begin
      case (regIdx)
        IDX_PORT_A_DATA: dataR.a <= wrByte;                                                 // R01 R05
        IDX_PORT_A_DIR:  dirR.a  <= wrByte;                                                 // R02 R08
        IDX_PORT_B_DATA: dataR.b <= wrByte;                                                 // R01 R05
        IDX_PORT_B_DIR:  dirR.b  <= wrByte;                                                 // R02
        IDX_PORT_C_DATA: dataR.c <= (wrByte & PORT_C_IMPL) | RST_PORT_C;                    // R04
        IDX_PORT_C_DIR:  dirR.c  <= (wrByte & PORT_C_IMPL) | RST_PORT_C;                    // R04
        IDX_PORT_D_DATA: dataR.d <= wrByte;                                                 // R01
        IDX_PORT_D_DIR:  dirR.d  <= wrByte;                                                 // R02
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Control registers and interrupt status.
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      misc_control     <= gpm_misc_type'(RST_MISC[5:0]);                                           // R11
      irqCfgR   <= 4'h0;
      irqMaskR  <= 4'h0;
      convChanR <= RST_CONV_CHAN;
    end else if (wrOk) begin
      case (regIdx)
        IDX_MISC_CTRL: begin
          // The slow bit can only be set; only reset clears it.
          misc_control.slowSel   <= misc_control.slowSel | wrByte[MISC_SLOW_BIT];                        // R12
          misc_control.usbTxSel  <= wrByte[MISC_USB_TX_BIT];                                       // R10
          misc_control.clkOutSel <= wrByte[MISC_CLK_OUT_BIT];                                      // R14
        end
        IDX_EXT_IRQ_CFG: irqCfgR   <= wrByte[3:0];                                          // R09
        IDX_IRQ_MASK:    irqMaskR  <= wrByte[3:0];
        IDX_CONV_CHAN:   convChanR <= wrByte[3:0];
        default: ;
      endcase
    end
  end

  // Events win over a clear in the same cycle.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      irqStatR     <= 4'h0;
      irqPinPrev_r <= 4'hF;
    end else begin
      irqStatR     <= irqStNxt;
      irqPinPrev_r <= irqPins;
    end
  end

  // ----------------------------------------------------------------------
  // Pin synchroniser, clock divider and registered outputs.
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pinMeta_r <= 32'h0000_0000;
      pinSync_r <= 32'h0000_0000;
      clkDiv_r  <= 1'b0;
    end else begin
      pinMeta_r <= pinIn;
      pinSync_r <= pinMeta_r;
      clkDiv_r  <= ~clkDiv_r;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prdata       <= 32'h0000_0000;
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      pinOut       <= 32'h0000_0000;
      pinOe        <= 32'h0000_0000;
      cpuClockSlow <= 1'b0;
      usbClockEn   <= 1'b0;
      extIrq5      <= 1'b0;
      extIrq6      <= 1'b0;
      extIrq7      <= 1'b0;
      extIrq8      <= 1'b0;
      extIrqAny    <= 1'b0;
      irq          <= 1'b0;
    end else begin
      pready       <= psel && !penable;
      pslverr      <= psel && !penable && !mapped;
      prdata       <= (psel && !penable && !pwrite && mapped) ? {24'h000000, rdByte} : 32'h0;
      pinOut       <= ownOut & ~analogSel;
      pinOe        <= ownOe & ~(openDrainMask & ownOut);
      // Divide enable for the CPU clock path; the USB path is never divided.
      cpuClockSlow <= misc_control.slowSel;                                                        // R12
      usbClockEn   <= 1'b1;                                                                 // R13
      extIrq5      <= irqLive[0] && !irqPins[0];
      extIrq6      <= irqLive[1] && !irqPins[1];
      extIrq7      <= irqLive[2] && !irqPins[2];
      extIrq8      <= irqLive[3] && !irqPins[3];
      extIrqAny    <= irqAnyNxt;                                                            // R16
      irq          <= |(irqStNxt & irqMaskR);
    end
  end

endmodule

`default_nettype wire

// file: test/gpm_ports_assertions.sv
/*
  Checker for the general-purpose port block, bound into every instance.
  Assumes only the block's ports are visible and one clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
module gpm_ports_assertions (
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] pinOut,
  input wire logic [31:0] pinOe,
  input wire logic [31:0] openDrainMask,
  input wire logic [31:0] altOutEn,
  input wire logic [31:0] altOutVal,
  input wire logic        cpuClockSlow,
  input wire logic        usbClockEn,
  input wire logic        extIrq5
);
  // Pin A0 and C2 carry other overrides, so they are left out here.
  logic [31:0] altMask;
  assign altMask = altOutEn & ~openDrainMask & 32'hFE000300;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence setup_s; psel && !penable; endsequence
  sequence answer_s; pready ##1 !pready; endsequence
  a_ready_after_setup: assert property (setup_s |=> answer_s)
    else $error("setup not answered by one ready pulse");
  a_ready_has_cause: assert property (pready |-> $past(psel && !penable))
    else $error("ready without a setup cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error flag outside the answer cycle");
  a_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bytes not zero");
  a_alt_forces_oe: assert property ($past(rst_b) |-> (pinOe & $past(altMask)) == $past(altMask))
    else $error("alternate output not driving its pin");
  a_alt_value: assert property ($past(rst_b) |->
    (pinOut & $past(altMask)) == ($past(altOutVal) & $past(altMask)))
    else $error("alternate output value not on its pin");
  a_slow_set_only: assert property (!$fell(cpuClockSlow))
    else $error("slow clock request dropped without reset");
  a_usb_clock_kept: assert property ($past(rst_b) |-> usbClockEn)
    else $error("usb clock stopped");
  a_output_no_irq: assert property ((pinOe[20] && !altOutEn[20]) [*3] |-> !extIrq5)
    else $error("output pin raised an interrupt");
endmodule
bind gpm_ports gpm_ports_assertions u_chk (.clock, .rst_b, .psel, .penable, .pwrite, .prdata,
  .pready, .pslverr, .pinOut, .pinOe, .openDrainMask, .altOutEn, .altOutVal, .cpuClockSlow,
  .usbClockEn, .extIrq5);
`default_nettype wire

// file: test/gpm_pin_model.sv
/*
  Board model for the port pins: resolves each pin from the block's
  drivers, the bench's external drivers and the pull-ups.
  Assumes the bench drives extVal and extEn in place of board parts.
*/
`timescale 1ns/1ns
`default_nettype none
module gpm_pin_model (
  input  wire logic        clock,
  input  wire logic [31:0] pinOut,
  input  wire logic [31:0] pinOe,
  input  wire logic [31:0] openDrainMask,
  input  wire logic [31:0] extVal,
  input  wire logic [31:0] extEn,
  output logic      [31:0] pinLevel
);
  localparam logic [31:0] PULL_UP = 32'hF900FFF0;
  // Floating pins wander every cycle so a stale level never passes.
  logic flip_r = 1'b0;
  always @(posedge clock) flip_r <= ~flip_r;
  assign pinLevel = (pinOe & ~openDrainMask & pinOut) | (~pinOe & extEn & extVal)
    | (~pinOe & ~extEn & (PULL_UP | {32{flip_r}}));
endmodule
`default_nettype wire

// file: test/gpm_ports_bench.sv
/*
  Self-checking bench for the port block: APB tasks, one task per test.
  Assumes the pin model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ns
`default_nettype none
module gpm_ports_bench;
  import gpm_pkg::*;
  logic        clock = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic        pready, pslverr, usbTransmitting = 0, smallPackage = 0, cpuClockSlow, usbClockEn;
  logic        extIrq5, extIrq6, extIrq7, extIrq8, extIrqAny, irq;
  logic [11:0] paddr = 0;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] pwdata = 0, prdata, pinIn, pinOut, pinOe, rd, extVal = 0, extEn = 0;
  logic [31:0] altOutEn = 0, altOutVal = 0, openDrainMask = 32'h02000000;
  int          err_count = 0, num_checks = 0;
  gpm_ports u_gpm_ports (.clock, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .pinIn, .pinOut, .pinOe, .openDrainMask, .altOutEn,
    .altOutVal, .usbTransmitting, .smallPackage, .cpuClockSlow, .usbClockEn,
    .extIrq5, .extIrq6, .extIrq7, .extIrq8, .extIrqAny, .irq);
  gpm_pin_model u_gpm_pin_model (.clock, .pinOut, .pinOe, .openDrainMask, .extVal, .extEn,
    .pinLevel(pinIn));
  always #4 clock = ~clock;
  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  function automatic logic [11:0] ad(logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk("pready", 0, 1);
    rd = prdata;
    er = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic wr(logic [7:0] i, logic [31:0] d); apb(1, ad(i), d); endtask
  task automatic rdc(string nm, logic [7:0] i, logic [31:0] exp);
    apb(0, ad(i), 0);
    chk(nm, rd, exp);
  endtask
  task automatic wt(int n); repeat (n) @(posedge clock); endtask
  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  task automatic t_reset;
    for (int k = 0; k < 4; k++) rdc("dir", 8'(2*k+1), k == 2 ? 32'hF0 : 32'h0);
    rdc("misc", IDX_MISC_CTRL, 32'h0);
    wr(IDX_PORT_A_DIR, 32'hFF);
    wt(2);
    chk("latchA", {24'h0, pinOut[31:24]}, 32'h0);
    chk("oeA", {24'h0, pinOe[31:24]}, 32'hFF);
    $display("test reset done");
  endtask
  task automatic t_latch;
    extEn <= 32'hFF; extVal <= 32'h3C;
    wr(IDX_PORT_D_DATA, 32'hA5);
    wt(3);
    rdc("inD", IDX_PORT_D_DATA, 32'h3C);
    wr(IDX_PORT_D_DIR, 32'h0F);
    wt(3);
    rdc("mixD", IDX_PORT_D_DATA, 32'h35);
    chk("outD", {28'h0, pinOut[3:0]}, 32'h5);
    chk("oeD", {24'h0, pinOe[7:0]}, 32'h0F);
    wr(IDX_CONV_CHAN, 32'h09);
    wt(2);
    chk("anaD", {24'h0, pinOe[7:0]}, 32'h0D);
    wr(IDX_CONV_CHAN, 32'h00);
    $display("test latch done");
  endtask
  task automatic t_portc;
    wr(IDX_PORT_C_DATA, 32'hFF);
    wr(IDX_PORT_C_DIR, 32'hFF);
    rdc("dirC", IDX_PORT_C_DIR, 32'hF7);
    rdc("datC", IDX_PORT_C_DATA, 32'hF7);
    chk("oeC", {24'h0, pinOe[15:8]}, 32'h07);
    wr(IDX_PORT_C_DATA, 32'h00);
    wr(IDX_MISC_CTRL, 32'h02);
    usbTransmitting <= 1;
    wt(2);
    chk("usbOn", {31'h0, pinOut[10]}, 32'h1);
    usbTransmitting <= 0;
    wt(2);
    chk("usbOff", {31'h0, pinOut[10]}, 32'h0);
    smallPackage <= 1;
    usbTransmitting <= 1;
    wt(2);
    chk("usbSmall", {30'h0, pinOe[17], pinOut[17]}, 32'h3);
    smallPackage <= 0;
    usbTransmitting <= 0;
    wr(IDX_PORT_C_DIR, 32'h00);
    altOutEn[9] <= 1; altOutVal[9] <= 1;
    wt(2);
    chk("altC", {30'h0, pinOe[9], pinOut[9]}, 32'h3);
    altOutEn[9] <= 0;
    $display("test port c done");
  endtask
  task automatic t_open;
    extEn[25] <= 1; extVal[25] <= 0;
    wr(IDX_PORT_A_DATA, 32'h02);
    wt(3);
    rdc("odLow", IDX_PORT_A_DATA, 32'h00);
    extVal[25] <= 1;
    wt(3);
    rdc("odHigh", IDX_PORT_A_DATA, 32'h02);
    $display("test open drain done");
  endtask
  task automatic t_misc;
    logic t;
    wr(IDX_PORT_A_DIR, 32'h00);
    wr(IDX_MISC_CTRL, 32'hFF);
    rdc("miscFF", IDX_MISC_CTRL, 32'h07);
    chk("slow", {31'h0, cpuClockSlow}, 32'h1);
    chk("mcoOe", {31'h0, pinOe[24]}, 32'h1);
    t = pinOut[24];
    wt(1);
    chk("mcoRun", {31'h0, pinOut[24]}, {31'h0, ~t});
    wr(IDX_MISC_CTRL, 32'h00);
    rdc("miscKeep", IDX_MISC_CTRL, 32'h04);
    chk("mcoOff", {31'h0, pinOe[24]}, 32'h0);
    chk("usbClk", {31'h0, usbClockEn}, 32'h1);
    $display("test misc done");
  endtask
  task automatic t_irq;
    extEn[23:16] <= 8'hFF; extVal[23:16] <= 8'hFF;
    wr(IDX_EXT_IRQ_CFG, 32'h0F);
    wr(IDX_IRQ_MASK, 32'h01);
    wr(IDX_IRQ_STATUS, 32'h0F);
    extVal[20] <= 0;
    wt(5);
    chk("irq5", {30'h0, extIrq5, irq}, 32'h3);
    rdc("stat5", IDX_IRQ_STATUS, 32'h01);
    extVal[21] <= 0;
    wt(5);
    chk("orAB", {29'h0, extIrq5, extIrq6, extIrqAny}, 32'h7);
    extVal[23:16] <= 8'hFF;
    wt(5);
    wr(IDX_IRQ_STATUS, 32'h0F);
    rdc("statClr", IDX_IRQ_STATUS, 32'h00);
    extVal[22] <= 0;
    wt(5);
    rdc("stat7", IDX_IRQ_STATUS, 32'h04);
    chk("masked", {30'h0, extIrq7, irq}, 32'h2);
    extVal[23] <= 0;
    wt(5);
    chk("irq8", {31'h0, extIrq8}, 32'h1);
    wr(IDX_EXT_IRQ_CFG, 32'h00);
    wt(3);
    chk("disabled", {31'h0, extIrqAny}, 32'h0);
    extEn[23:16] <= 8'h00;
    wr(IDX_IRQ_STATUS, 32'h0F);
    // Outputs first: floating inputs would fire as soon as the sources are enabled.
    wr(IDX_PORT_B_DATA, 32'h00);
    wr(IDX_PORT_B_DIR, 32'hF0);
    wr(IDX_EXT_IRQ_CFG, 32'h0F);
    wt(5);
    chk("outNoIrq", {31'h0, extIrqAny}, 32'h0);
    rdc("statOut", IDX_IRQ_STATUS, 32'h00);
    $display("test interrupt done");
  endtask
  task automatic t_err;
    apb(0, 12'h020, 0);
    chk("unmapped", {er, rd[30:0]}, 32'h80000000);
    apb(0, 12'h002, 0);
    chk("misalign", {31'h0, er}, 32'h1);
    $display("test refusal done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clock);
    rst_b <= 1;
    t_reset;
    t_latch;
    t_portc;
    t_open;
    t_misc;
    t_irq;
    t_err;
    final_report;
  end
  // The tests need well under 2000 cycles; this limit leaves wide margin.
  initial begin
    #200000;
    err_count++;
    final_report;
  end
endmodule
`default_nettype wire
